/* File: rtl/core_alu_and_io_bit_ops.v */
// eight-bit arithmetic and logic datapath with word ops and io bit ops
`include "alu_consts.vh"
// Behaviour
// - add and add-with-carry write dest plus src (plus carry); flags Z,C,N,V,H
// - word increase adds constant to high:low pair over two cycles; Z,C,N,V,S
// - register difference stores dest minus src in one cycle; Z,C,N,V,H
// - constant difference stores dest minus constant in one cycle; Z,C,N,V,H
// - borrow difference stores dest minus src minus carry; Z,C,N,V,H
// - borrow constant difference stores dest minus constant minus carry; Z,C,N,V,H
// - word decrease subtracts constant from high:low pair over two cycles
// - register AND stores dest and src; only Z,N,V change
// - constant AND stores dest and constant; only Z,N,V change
// - register OR stores dest or src; only Z,N,V change
// - constant OR stores dest or constant; only Z,N,V change
// - register XOR stores dest xor src; only Z,N,V change
// - low io registers support bit set, bit clear and bit tests
// - bit set and clear touch only the addressed bit
// - some status flags clear when software writes one to them
// - bit set and clear reach only addresses up to the low boundary
module core_alu_and_io_bit_ops
#(
   parameter W1C_MASK = 32'h0000_0000
)
(
   input  wire       clk_sys_i,
   input  wire       sys_rst_i,
   input  wire       start_i,
   input  wire [3:0] op_i,
   input  wire [7:0] dest_i,
   input  wire [7:0] src_i,
   input  wire [7:0] imm_i,
   input  wire [7:0] word_hi_i,
   input  wire [5:0] word_k_i,
   input  wire [7:0] io_addr_i,
   input  wire [2:0] io_bit_i,
   input  wire       skip_test_i,
   input  wire       skip_on_high_i,
   input  wire [7:0] hw_set_i,
   input  wire [4:0] hw_addr_i,
   output reg  [7:0] result_o,
   output reg  [7:0] result_hi_o,
   output reg        result_valid_o,
   output reg        word_result_o,
   output reg  [5:0] flags_o,
   output reg        busy_o,
   output reg        skip_o,
   output reg        io_range_err_o,
   output reg  [7:0] io_data_o
);
   // ************************************************************
   // interface timing and flag summary
   // ************************************************************
   // request side
   //    start_i is sampled on every rising edge while the unit is idle
   //    op_i, dest_i, src_i, imm_i, word_hi_i and word_k_i must be valid there
   //    start_i is ignored in the second cycle of a word op (busy_o high)
   //    a caller that keeps start_i high simply issues the same op again
   // byte ops
   //    answer one edge after the request: result_o, flags_o, result_valid_o
   //    result_o and flags_o hold until the next op writes them
   //    result_valid_o is a one-cycle pulse
   // word ops
   //    low byte is formed in the first cycle, high byte in the second
   //    the low-byte carry is kept in carry_reg for the high-byte pass
   //    flags move only in the second cycle, from the full 16-bit result
   //    result_o already shows the low byte after the first cycle
   //    result_hi_o changes only when a word op completes
   //    busy_o is high for exactly the cycle between the two passes
   // ordering
   //    byte ops may follow each other on every edge
   //    a word op needs two edges before the next request is taken
   //    a bit test and a byte op may share one edge
   //    an io set or clear and a bit test in one edge: the test sees the old value
   // flag word layout
   //    bit 0 carry, bit 1 zero, bit 2 negative
   //    bit 3 overflow, bit 4 sign, bit 5 half carry
   //    every flag an op does not list keeps its value
   //    byte arithmetic leaves sign alone; logic ops leave carry, sign, half carry
   //    logic ops always clear overflow
   //    word ops leave half carry alone
   // io bit space
   //    set and clear reach addresses 0x00 to 0x1F only
   //    a set or clear above that is dropped and io_range_err_o pulses
   //    bit tests above that range never raise skip_o
   //    io_data_o shows the addressed register one cycle late
   //    hardware status sets always win over a software clear in the same cycle
   //    registers marked in W1C_MASK clear a bit when software sets it
   //    on those registers a software clear does nothing
   // reset
   //    asynchronous, active high; first request may come at the first edge after
   //    outputs, flags and io registers are all zero during reset
   // hazards and limits
   //    operands come from same-clock logic, so no synchronisers are placed
   //    the carry used by carry ops is the registered flag, not a bypass
   //    so two carry ops back to back see each other's carry as expected
   //    word ops must not be followed by a request in their busy cycle
   //    skip tests during the busy cycle are dropped as well
   // ************************************************************
   // state and working registers
   // ************************************************************
   localparam ST_IDLE = 1'b0;
   localparam ST_HIGH = 1'b1;

   reg        state_reg;
   reg        state_next;
   reg  [7:0] hi_reg;
   reg  [7:0] hi_orig_reg;
   reg  [7:0] lo_res_reg;
   reg        carry_reg;
   reg        sub_reg;
   reg  [5:0] flags_next;
   reg  [7:0] res_next;
   reg  [7:0] op_a;
   reg  [7:0] op_b;
   reg        op_cin;
   reg        op_sub;
   reg  [7:0] logic_res;

   wire [7:0] calc_res;
   wire       calc_c;
   wire       calc_h;
   wire       calc_v;
   wire       io_hit;
   wire       io_bit_val;
   wire [7:0] io_rd;
   wire       c_in;
   wire       io_set_req;
   wire       io_clr_req;

   assign c_in   = flags_o[`FLAG_C];
   // io bit ops only reach the low range
   assign io_hit = (io_addr_i <= {3'b000, `IO_LOW_MAX});

   // taken io requests; out-of-range ones never reach the io space
   assign io_set_req = start_i && (state_reg == ST_IDLE) && (op_i == `OP_IO_SET) && io_hit;
   assign io_clr_req = start_i && (state_reg == ST_IDLE) && (op_i == `OP_IO_CLR) && io_hit;

   // ************************************************************
   // operand selection
   // ************************************************************
   // immediate forms share the adder with register forms
   // second word cycle: high byte plus or minus the low-byte carry only
   // register forms take src_i, constant forms imm_i, word forms word_k_i
   // carry ops take the held carry flag as carry or borrow in
   always @*
   begin
      op_a   = dest_i;
      op_b   = src_i;
      op_cin = 1'b0;
      op_sub = 1'b0;
      if (state_reg == ST_HIGH)
      begin
         op_a   = hi_reg;
         op_b   = 8'h00;
         op_cin = carry_reg;
         op_sub = sub_reg;
      end
      else
      begin
         case (op_i)
            `OP_ADD      : op_b = src_i;
            `OP_ADC      : op_cin = c_in;
            `OP_WORD_INC : op_b = {2'b00, word_k_i};
            `OP_SUB      : op_sub = 1'b1;
            `OP_CONST_DIFF :
            begin
               op_b   = imm_i;
               op_sub = 1'b1;
            end
            `OP_BORROW_DIFF :
            begin
               op_sub = 1'b1;
               op_cin = c_in;
            end
            `OP_BORROW_IMM :
            begin
               op_b   = imm_i;
               op_sub = 1'b1;
               op_cin = c_in;
            end
            `OP_WORD_DEC :
            begin
               op_b   = {2'b00, word_k_i};
               op_sub = 1'b1;
            end
            default      : op_b = src_i;
         endcase
      end
   end

   alu_flag_calc i_alu_flag_calc
   (
      .a_i   (op_a),
      .b_i   (op_b),
      .cin_i (op_cin),
      .sub_i (op_sub),
      .res_o (calc_res),
      .c_o   (calc_c),
      .h_o   (calc_h),
      .v_o   (calc_v)
   );

   io_bit_space #(.W1C_MASK(W1C_MASK)) i_io_bit_space
   (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .bit_set_i (io_set_req),
      .bit_clr_i (io_clr_req),
      .addr_i    (io_addr_i[4:0]),
      .bit_i     (io_bit_i),
      .hw_set_i  (hw_set_i),
      .hw_addr_i (hw_addr_i),
      .bit_val_o (io_bit_val),
      .rd_data_o (io_rd)
   );

   // ************************************************************
   // result and flag computation
   // ************************************************************
   // untouched flags default to their held value
   always @*
   begin
      flags_next = flags_o;
      res_next   = result_o;
      state_next = state_reg;
      logic_res  = 8'h00;
      if (state_reg == ST_HIGH)
      begin
         // second word cycle: high byte, flags from the full 16-bit result
         // add: overflow when a positive high byte turns negative
         // add: carry out when the high byte wraps from negative to positive
         // sub: overflow when a negative high byte turns positive
         // sub: borrow when the high byte wraps from positive to negative
         // zero needs both bytes, so the low byte result is kept
         res_next               = calc_res;
         flags_next[`FLAG_Z]    = (calc_res == 8'h00) && (lo_res_reg == 8'h00);
         flags_next[`FLAG_N]    = calc_res[7];
         flags_next[`FLAG_V]    = sub_reg ? (hi_orig_reg[7] & ~calc_res[7])
                                          : (~hi_orig_reg[7] & calc_res[7]);
         flags_next[`FLAG_C]    = sub_reg ? (calc_res[7] & ~hi_orig_reg[7])
                                          : (~calc_res[7] & hi_orig_reg[7]);
         flags_next[`FLAG_S]    = flags_next[`FLAG_N] ^ flags_next[`FLAG_V];
         state_next             = ST_IDLE;
      end
      else if (start_i)
      begin
         case (op_i)
            `OP_ADD, `OP_ADC, `OP_SUB, `OP_CONST_DIFF, `OP_BORROW_DIFF, `OP_BORROW_IMM :
            begin
               res_next            = calc_res;
               flags_next[`FLAG_C] = calc_c;
               flags_next[`FLAG_H] = calc_h;
               flags_next[`FLAG_V] = calc_v;
               flags_next[`FLAG_N] = calc_res[7];
               flags_next[`FLAG_Z] = (calc_res == 8'h00);
            end
            `OP_WORD_INC, `OP_WORD_DEC :
            begin
               res_next   = calc_res; // low byte, flags wait for the high byte
               state_next = ST_HIGH;
            end
            `OP_AND, `OP_AND_CONST, `OP_OR, `OP_OR_CONST, `OP_XOR :
            begin
               case (op_i)
                  `OP_AND       : logic_res = dest_i & src_i;
                  `OP_AND_CONST : logic_res = dest_i & imm_i;
                  `OP_OR        : logic_res = dest_i | src_i;
                  `OP_OR_CONST  : logic_res = dest_i | imm_i;
                  default  : logic_res = dest_i ^ src_i;
               endcase
               res_next            = logic_res;
               flags_next[`FLAG_Z] = (logic_res == 8'h00);
               flags_next[`FLAG_N] = logic_res[7];
               flags_next[`FLAG_V] = 1'b0;
            end
            default : res_next = result_o;
         endcase
      end
   end

   // ************************************************************
   // registered state
   // ************************************************************
   // all outputs straight from flops; word ops hold busy one cycle
   always @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state_reg      <= ST_IDLE;
         hi_reg         <= 8'h00;
         hi_orig_reg    <= 8'h00;
         lo_res_reg     <= 8'h00;
         carry_reg      <= 1'b0;
         sub_reg        <= 1'b0;
         result_o       <= 8'h00;
         result_hi_o    <= 8'h00;
         result_valid_o <= 1'b0;
         word_result_o  <= 1'b0;
         flags_o        <= `FLAGS_RESET;
         busy_o         <= 1'b0;
         skip_o         <= 1'b0;
         io_range_err_o <= 1'b0;
         io_data_o      <= 8'h00;
      end
      else
      begin
         state_reg      <= state_next;
         flags_o        <= flags_next;
         result_o       <= res_next;
         busy_o         <= (state_next == ST_HIGH);
         result_valid_o <= 1'b0;
         word_result_o  <= 1'b0;
         skip_o         <= 1'b0;
         io_range_err_o <= 1'b0;
         io_data_o      <= io_rd;
         if (state_reg == ST_IDLE && start_i)
         begin
            hi_reg      <= word_hi_i;
            hi_orig_reg <= word_hi_i;
            lo_res_reg  <= calc_res;
            carry_reg   <= calc_c;
            sub_reg     <= (op_i == `OP_WORD_DEC);
            // io ops and idle cycles give no result pulse
            // word ops pulse on completion, further below
            result_valid_o <= (op_i != `OP_WORD_INC) && (op_i != `OP_WORD_DEC)
                              && (op_i != `OP_IO_SET) && (op_i != `OP_IO_CLR)
                              && (op_i != `OP_NONE);
            // set/clear out of range is dropped and flagged
            io_range_err_o <= ((op_i == `OP_IO_SET) || (op_i == `OP_IO_CLR)) && !io_hit;
         end
         if (state_reg == ST_HIGH)
         begin
            // second cycle: publish both bytes together
            result_o       <= lo_res_reg;
            result_hi_o    <= res_next;
            result_valid_o <= 1'b1;
            word_result_o  <= 1'b1;
         end
         // skip decision from the addressed io bit
         if (skip_test_i && state_reg == ST_IDLE && io_hit)
            skip_o <= (io_bit_val == skip_on_high_i);
      end
   end
endmodule // core_alu_and_io_bit_ops

/* File: pkg/alu_consts.vh */
// constants shared by the datapath, the io bit space, the checker and the bench
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH
// operation codes
`define OP_NONE        4'h0
`define OP_ADD         4'h1
`define OP_ADC         4'h2
`define OP_WORD_INC    4'h3
`define OP_SUB         4'h4
`define OP_CONST_DIFF  4'h5
`define OP_BORROW_DIFF 4'h6
`define OP_BORROW_IMM  4'h7
`define OP_WORD_DEC    4'h8
`define OP_AND         4'h9
`define OP_AND_CONST   4'hA
`define OP_OR          4'hB
`define OP_OR_CONST    4'hC
`define OP_XOR         4'hD
`define OP_IO_SET      4'hE
`define OP_IO_CLR      4'hF
// status flag positions
`define FLAG_C         0
`define FLAG_Z         1
`define FLAG_N         2
`define FLAG_V         3
`define FLAG_S         4
`define FLAG_H         5
// io space
`define IO_LOW_MAX     5'h1F
`define IO_ADDR_W      5
`define IO_REGS        32
`define FLAGS_RESET    6'h00
`define IO_RESET       8'h00
// cycle counts
`define SINGLE_CYCLES  1
`define WORD_CYCLES    2
`endif

/* File: rtl/alu_flag_calc.v */
// byte arithmetic core with carry, half carry and overflow outputs
module alu_flag_calc
(
   input  wire [7:0] a_i,
   input  wire [7:0] b_i,
   input  wire       cin_i,
   input  wire       sub_i,
   output wire [7:0] res_o,
   output wire       c_o,
   output wire       h_o,
   output wire       v_o
);
   wire [7:0] b_eff;
   wire [8:0] sum;
   wire [4:0] low;

   // subtract as add of inverted operand; carry out is inverted to a borrow
   assign b_eff = sub_i ? ~b_i : b_i;
   assign sum   = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, sub_i ^ cin_i};
   assign low   = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub_i ^ cin_i};
   assign res_o = sum[7:0];
   assign c_o   = sum[8] ^ sub_i;
   assign h_o   = low[4] ^ sub_i;
   assign v_o   = (a_i[7] == b_eff[7]) && (sum[7] != a_i[7]);
endmodule // alu_flag_calc

/* File: rtl/io_bit_space.v */
// low io register space with bit set, bit clear, write-one-to-clear and bit test
`include "alu_consts.vh"
module io_bit_space
#(
   parameter W1C_MASK = 32'h0000_0000
)
(
   input  wire       clk_sys_i,
   input  wire       sys_rst_i,
   input  wire       bit_set_i,
   input  wire       bit_clr_i,
   input  wire [4:0] addr_i,
   input  wire [2:0] bit_i,
   input  wire [7:0] hw_set_i,
   input  wire [4:0] hw_addr_i,
   output wire       bit_val_o,
   output wire [7:0] rd_data_o
);
   reg  [7:0] io_mem [0:`IO_REGS-1];
   wire [7:0] bit_mask;

   assign bit_mask = 8'h01 << bit_i;

   // one register per address; a hardware set beats a software clear
   genvar g;
   generate
      for (g = 0; g < `IO_REGS; g = g + 1)
      begin : g_io
         wire [7:0] hw_bits;

         // hardware sets are or-ed in last, so they win over any clear
         assign hw_bits = (hw_addr_i == g) ? hw_set_i : 8'h00;

         always @(posedge clk_sys_i or posedge sys_rst_i)
         begin
            if (sys_rst_i)
               io_mem[g] <= `IO_RESET;
            // only the addressed bit changes
            else if ((addr_i == g) && bit_set_i && W1C_MASK[g])
               io_mem[g] <= (io_mem[g] & ~bit_mask) | hw_bits;
            else if ((addr_i == g) && bit_set_i)
               io_mem[g] <= io_mem[g] | bit_mask | hw_bits;
            else if ((addr_i == g) && bit_clr_i && !W1C_MASK[g])
               io_mem[g] <= (io_mem[g] & ~bit_mask) | hw_bits;
            else
               io_mem[g] <= io_mem[g] | hw_bits;
         end
      end
   endgenerate

   // bit test feeds the skip decisions
   assign rd_data_o = io_mem[addr_i];
   assign bit_val_o = rd_data_o[bit_i];
endmodule // io_bit_space

/* File: tb/core_alu_and_io_bit_ops_chk.sv */
// assertion checker watching the datapath ports
`include "alu_consts.vh"
module core_alu_and_io_bit_ops_chk
(
   input wire       clk_sys_i,
   input wire       sys_rst_i,
   input wire       start_i,
   input wire [3:0] op_i,
   input wire [7:0] dest_i,
   input wire [7:0] src_i,
   input wire [7:0] io_addr_i,
   input wire [7:0] result_o,
   input wire       result_valid_o,
   input wire       word_result_o,
   input wire [5:0] flags_o,
   input wire       busy_o,
   input wire       io_range_err_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ********
   // request decode
   // ********
   // busy covers the second word cycle, so go marks only taken requests
   wire go       = start_i && !busy_o;
   wire logic_op = op_i >= `OP_AND && op_i <= `OP_XOR;
   wire word_op  = op_i == `OP_WORD_INC || op_i == `OP_WORD_DEC;
   wire arith_op = op_i inside {`OP_ADD, `OP_ADC, `OP_SUB, `OP_CONST_DIFF, `OP_BORROW_DIFF,
                                `OP_BORROW_IMM};
   wire io_op    = op_i == `OP_IO_SET || op_i == `OP_IO_CLR;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   // ********
   // timing and flag relations
   // ********
   property p_byte_answer;
      go && (logic_op || arith_op) |-> ##1 result_valid_o && !word_result_o && !busy_o;
   endproperty
   a_byte_answer: assert property (p_byte_answer) else $error("byte answer late");
   property p_word_answer;
      go && word_op |-> ##1 busy_o ##1 (result_valid_o && word_result_o && !busy_o);
   endproperty
   a_word_answer: assert property (p_word_answer) else $error("word answer wrong");
   property p_word_sign;
      word_result_o |-> flags_o[`FLAG_S] == (flags_o[`FLAG_N] ^ flags_o[`FLAG_V]);
   endproperty
   a_word_sign: assert property (p_word_sign) else $error("word sign flag wrong");
   property p_logic_flags;
      go && logic_op |-> ##1 !flags_o[`FLAG_V] && flags_o[`FLAG_Z] == (result_o == 8'h00)
         && flags_o[`FLAG_N] == result_o[7];
   endproperty
   a_logic_flags: assert property (p_logic_flags) else $error("logic flags wrong");
   property p_logic_hold;
      go && logic_op |-> ##1 $stable({flags_o[`FLAG_H], flags_o[`FLAG_S], flags_o[`FLAG_C]});
   endproperty
   a_logic_hold: assert property (p_logic_hold) else $error("logic op moved a flag");
   property p_arith_hold;
      go && arith_op |-> ##1 $stable(flags_o[`FLAG_S]);
   endproperty
   a_arith_hold: assert property (p_arith_hold) else $error("byte op moved sign");
   property p_word_hold;
      go && word_op |-> ##2 flags_o[`FLAG_H] == $past(flags_o[`FLAG_H], 2);
   endproperty
   a_word_hold: assert property (p_word_hold) else $error("word op moved half carry");
   property p_add_value;
      go && op_i == `OP_ADD |-> ##1
         {flags_o[`FLAG_C], result_o} == {1'b0, $past(dest_i)} + {1'b0, $past(src_i)};
   endproperty
   a_add_value: assert property (p_add_value) else $error("sum or carry wrong");
   property p_range_err;
      go && io_op |-> ##1 io_range_err_o == ($past(io_addr_i) > `IO_LOW_MAX);
   endproperty
   a_range_err: assert property (p_range_err) else $error("range error wrong");
endmodule // core_alu_and_io_bit_ops_chk

bind core_alu_and_io_bit_ops core_alu_and_io_bit_ops_chk i_core_alu_and_io_bit_ops_chk
(
   .clk_sys_i, .sys_rst_i, .start_i, .op_i, .dest_i, .src_i, .io_addr_i,
   .result_o, .result_valid_o, .word_result_o, .flags_o, .busy_o, .io_range_err_o
);

/* File: tb/core_alu_and_io_bit_ops_bench.sv */
// self-checking bench for byte, word and io bit operations
`include "alu_consts.vh"
module core_alu_and_io_bit_ops_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_sys_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic       start_i = 1'b0, skip_test_i = 1'b0, skip_on_high_i = 1'b0;
   logic [3:0] op_i = 4'h0;
   logic [7:0] dest_i = 8'h00, src_i = 8'h00, imm_i = 8'h00, word_hi_i = 8'h00;
   logic [7:0] io_addr_i = 8'h00, hw_set_i = 8'h00;
   logic [5:0] word_k_i = 6'h00;
   logic [4:0] hw_addr_i = 5'h00;
   logic [2:0] io_bit_i = 3'h0;
   wire  [7:0] result_o, result_hi_o, io_data_o;
   wire  [5:0] flags_o;
   wire        result_valid_o, word_result_o, busy_o, skip_o, io_range_err_o;
   logic [5:0] ef = 6'h00;
   logic [7:0] er;
   int         n_mismatch = 0, checks_done = 0;
   // io register 8 behaves as write-one-to-clear status
   core_alu_and_io_bit_ops #(.W1C_MASK(32'h0000_0100)) i_core_alu_and_io_bit_ops
   (
      .clk_sys_i, .sys_rst_i, .start_i, .op_i, .dest_i, .src_i, .imm_i, .word_hi_i,
      .word_k_i, .io_addr_i, .io_bit_i, .skip_test_i, .skip_on_high_i, .hw_set_i,
      .hw_addr_i, .result_o, .result_hi_o, .result_valid_o, .word_result_o, .flags_o,
      .busy_o, .skip_o, .io_range_err_o, .io_data_o
   );
   always #25 clk_sys_i = ~clk_sys_i;
   // ********
   // access tasks
   // ********
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one operation, expected flags kept in ef (bits H S V N Z C)
   task automatic run(input logic [3:0] op, input logic [7:0] d, s, k, hi);
      logic [8:0]  t;
      logic [16:0] w;
      logic [4:0]  lo;
      logic [7:0]  b;
      logic        sb, cy, v, wd;
      begin
         b  = (op inside {`OP_CONST_DIFF, `OP_BORROW_IMM, `OP_AND_CONST, `OP_OR_CONST}) ? k : s;
         sb = op inside {`OP_SUB, `OP_CONST_DIFF, `OP_BORROW_DIFF, `OP_BORROW_IMM, `OP_WORD_DEC};
         cy = (op inside {`OP_ADC, `OP_BORROW_DIFF, `OP_BORROW_IMM}) & ef[0];
         wd = op inside {`OP_WORD_INC, `OP_WORD_DEC};
         t  = sb ? {1'b0, d} - b - cy : {1'b0, d} + b + cy;
         lo = sb ? {1'b0, d[3:0]} - b[3:0] - cy : {1'b0, d[3:0]} + b[3:0] + cy;
         w  = sb ? {1'b0, hi, d} - k[5:0] : {1'b0, hi, d} + k[5:0];
         {op_i, dest_i, src_i, imm_i, word_hi_i, word_k_i} = {op, d, s, k, hi, k[5:0]};
         start_i = 1'b1;
         @(posedge clk_sys_i);
         #2;
         if (wd)
         begin
            chk(busy_o, 1'b1);
            @(posedge clk_sys_i);
            #2;
            v  = (hi[7] ^ w[15]) & (hi[7] == sb);
            ef = {ef[5], w[15] ^ v, v, w[15], w[15:0] == 16'h0000, w[16]};
            er = w[7:0];
            chk(result_hi_o, w[15:8]);
         end
         else if (op >= `OP_AND)
         begin
            er = (op <= `OP_AND_CONST) ? d & b : (op <= `OP_OR_CONST) ? d | b : d ^ b;
            ef = {ef[5], ef[4], 1'b0, er[7], er == 8'h00, ef[0]};
         end
         else
         begin
            v  = (d[7] ^ t[7]) & ((d[7] ^ b[7]) == sb);
            ef = {lo[4], ef[4], v, t[7], t[7:0] == 8'h00, t[8]};
            er = t[7:0];
         end
         chk(result_o, er);
         chk(flags_o, ef);
         chk({result_valid_o, word_result_o}, {1'b1, wd});
      end
   endtask
   task automatic io_op(input logic [3:0] op, input logic [7:0] a, input logic [2:0] b);
      {op_i, io_addr_i, io_bit_i} = {op, a, b};
      start_i = 1'b1;
      skip_test_i = 1'b0;
      @(posedge clk_sys_i);
      #2;
      chk(io_range_err_o, a > 8'h1F);
   endtask
   // io data lags the address by a cycle, so two edges pass
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      start_i = 1'b0;
      io_addr_i = a;
      repeat (2) @(posedge clk_sys_i);
      #2;
      chk(io_data_o, e);
   endtask
   task automatic skip(input logic [7:0] a, input logic [2:0] b, input logic h, e);
      {io_addr_i, io_bit_i, skip_on_high_i} = {a, b, h};
      skip_test_i = 1'b1;
      @(posedge clk_sys_i);
      #2;
      chk(skip_o, e);
   endtask
   task give_verdict;
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ********
   // test sequence
   // ********
   initial
   begin
      repeat (12) @(posedge clk_sys_i);
      #2;
      sys_rst_i = 1'b0;
      chk(flags_o, 6'h00);
      run(`OP_ADD, 8'h78, 8'h08, 8'h00, 8'h00);
      run(`OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h00);
      run(`OP_ADC, 8'h10, 8'h20, 8'h00, 8'h00);
      run(`OP_SUB, 8'h10, 8'h20, 8'h00, 8'h00);
      run(`OP_CONST_DIFF, 8'h3F, 8'h00, 8'h40, 8'h00);
      run(`OP_BORROW_DIFF, 8'h50, 8'h0F, 8'h00, 8'h00);
      run(`OP_BORROW_IMM, 8'h00, 8'h00, 8'h01, 8'h00);
      run(`OP_BORROW_IMM, 8'h05, 8'h00, 8'h01, 8'h00);
      run(`OP_AND, 8'hF0, 8'h3C, 8'h00, 8'h00);
      run(`OP_AND_CONST, 8'h0F, 8'hFF, 8'h80, 8'h00);
      run(`OP_OR, 8'h80, 8'h01, 8'h00, 8'h00);
      run(`OP_OR_CONST, 8'h00, 8'hFF, 8'h00, 8'h00);
      run(`OP_XOR, 8'h5A, 8'h5A, 8'h00, 8'h00);
      run(`OP_WORD_INC, 8'hFF, 8'h00, 8'h01, 8'hFF);
      run(`OP_WORD_INC, 8'hFF, 8'h00, 8'h3F, 8'h7F);
      run(`OP_WORD_DEC, 8'h00, 8'h00, 8'h3F, 8'h00);
      run(`OP_SUB, 8'h80, 8'h01, 8'h00, 8'h00);
      io_op(`OP_IO_SET, 8'h03, 3'h2);
      io_op(`OP_IO_SET, 8'h03, 3'h7);
      rd(8'h03, 8'h84);
      io_op(`OP_IO_CLR, 8'h03, 3'h2);
      rd(8'h03, 8'h80);
      skip(8'h03, 3'h7, 1'b1, 1'b1);
      skip(8'h03, 3'h2, 1'b1, 1'b0);
      skip(8'h03, 3'h2, 1'b0, 1'b1);
      io_op(`OP_IO_SET, 8'h20, 3'h0);
      rd(8'h00, 8'h00);
      io_op(`OP_IO_SET, 8'h1F, 3'h0);
      rd(8'h1F, 8'h01);
      {hw_addr_i, hw_set_i} = {5'h08, 8'h0A};
      @(posedge clk_sys_i);
      #2;
      hw_set_i = 8'h00;
      rd(8'h08, 8'h0A);
      io_op(`OP_IO_SET, 8'h08, 3'h1);
      io_op(`OP_IO_CLR, 8'h08, 3'h3);
      rd(8'h08, 8'h08);
      // hardware set in the same cycle as a software clear must win
      hw_set_i = 8'h08;
      io_op(`OP_IO_SET, 8'h08, 3'h3);
      {hw_addr_i, hw_set_i} = {5'h03, 8'h80};
      io_op(`OP_IO_CLR, 8'h03, 3'h7);
      hw_set_i = 8'h00;
      rd(8'h03, 8'h80);
      rd(8'h08, 8'h08);
      give_verdict();
   end
   // the sequence needs some 60 cycles; 400 leaves ample margin
   initial
   begin
      #(400 * 50);
      n_mismatch++;
      give_verdict();
   end
endmodule // core_alu_and_io_bit_ops_bench
